// [hdl/acrmc_top.sv]
`timescale 1ns/1ps
`include "acrmc_defines.svh"

module acrmc_top #(
    parameter int INT_DIV = `ACRMC_INT_DIV
) (
    input  wire logic       clock,
    input  wire logic       reset,
    // Serial link pins, sampled by the block clock
    input  wire logic       serial_clock,
    input  wire logic       chip_select_n,
    input  wire logic       serial_data_in,
    input  wire logic       conversion_start_pin_n,
    // Scan requests from the sequencer
    input  wire logic       scan_request,
    input  wire logic       scan_temperature,
    input  wire logic       scan_done,
    input  wire logic       reference_override,
    // Decoded setup state
    output logic [1:0]      clock_mode_select,
    output logic [1:0]      reference_mode_select,
    output logic [1:0]      pair_mode_target_select,
    output logic            use_internal_conv_clock,
    output logic            host_timed_acquisition,
    output logic            serial_timed_acquisition,
    output logic            shared_pin_is_start,
    output logic            shared_pin_is_reference,
    output logic            adc_uses_internal_reference,
    output logic            adc_differential_reference,
    output logic            internal_reference_on,
    output logic [7:0]      unipolar_pairs,
    output logic [7:0]      bipolar_pairs,
    output logic            start_request,
    output logic            conversion_go,
    output logic            temperature_ready
);
    // =========================================================
    // Pin sampling
    // =========================================================
    logic [3:0] pin_level;
    logic [3:0] pin_rise;

    // Select enters inverted so an idle bus matches the sampler's reset level
    acrmc_pin_sync #(.WIDTH(4)) u_sync (
        .clock (clock),
        .reset (reset),
        .pin   ({serial_clock, !chip_select_n, serial_data_in, !conversion_start_pin_n}),
        .level (pin_level),
        .rise  (pin_rise)
    );

    logic sclk_rise;
    logic cs_active;
    logic sdi_level;
    logic start_rise;
    assign sclk_rise  = pin_rise[3];
    assign cs_active  = pin_level[2];
    assign sdi_level  = pin_level[1];
    assign start_rise = pin_rise[0];

    // =========================================================
    // Serial byte assembly
    // =========================================================
    logic [7:0] shift_q;
    logic [2:0] bit_cnt_q;
    logic       byte_done;
    logic [7:0] byte_val;

    assign byte_val  = {shift_q[6:0], sdi_level};
    assign byte_done = cs_active && sclk_rise && (bit_cnt_q == 3'h7);

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            shift_q   <= 8'h00;
            bit_cnt_q <= 3'h0;
        end else if (!cs_active) begin
            bit_cnt_q <= 3'h0;
        end else if (sclk_rise) begin
            shift_q   <= byte_val;
            bit_cnt_q <= bit_cnt_q + 3'h1;
        end
    end

    // =========================================================
    // Setup decode and pair register steering
    // =========================================================
    logic pending_q;
    logic pair_bip_q;
    logic is_setup;

    assign is_setup = (byte_val[`ACRMC_ID_HI:`ACRMC_ID_LO] == `ACRMC_SETUP_ID); // [RULE15]

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            clock_mode_select       <= `ACRMC_CLK_RESET; // [RULE16]
            reference_mode_select   <= `ACRMC_REF_RESET; // [RULE11]
            pair_mode_target_select <= 2'h0;
            pending_q               <= 1'b0;
            pair_bip_q              <= 1'b0;
            unipolar_pairs          <= `ACRMC_PAIR_RESET;
            bipolar_pairs           <= `ACRMC_PAIR_RESET;
        end else if (!cs_active) begin
            // Select raised before the data byte abandons the write
            pending_q <= 1'b0;
        end else if (byte_done) begin
            if (pending_q) begin
                pending_q <= 1'b0;
                if (pair_bip_q) begin
                    bipolar_pairs <= byte_val; // [RULE14]
                end else begin
                    unipolar_pairs <= byte_val; // [RULE13]
                end
            end else if (is_setup) begin
                clock_mode_select       <= byte_val[`ACRMC_CLK_HI:`ACRMC_CLK_LO];
                reference_mode_select   <= byte_val[`ACRMC_REF_HI:`ACRMC_REF_LO];
                pair_mode_target_select <= byte_val[`ACRMC_PAIR_HI:`ACRMC_PAIR_LO];
                pending_q               <= byte_val[`ACRMC_PAIR_HI]; // [RULE18] [RULE17]
                pair_bip_q              <= byte_val[`ACRMC_PAIR_LO];
            end
        end
    end

    // =========================================================
    // Mode outputs
    // =========================================================
    acrmc_pkg::acrmc_clk_mode_t ck;
    acrmc_pkg::acrmc_ref_mode_t rf;
    assign ck = acrmc_pkg::acrmc_clk_mode_t'(clock_mode_select);
    assign rf = acrmc_pkg::acrmc_ref_mode_t'(reference_mode_select);

    logic ext_clk;
    assign ext_clk = (ck == acrmc_pkg::ACRMC_CLK_EXTERNAL); // [RULE3]

    assign use_internal_conv_clock     = !ext_clk; // [RULE1]
    assign shared_pin_is_start         = !clock_mode_select[1]; // [RULE1]
    assign host_timed_acquisition      = (ck == acrmc_pkg::ACRMC_CLK_INT_EXT_ACQ); // [RULE2]
    assign serial_timed_acquisition    = ext_clk; // [RULE3]
    assign shared_pin_is_reference     = rf[0]; // [RULE10] [RULE12]
    assign adc_uses_internal_reference = !rf[0]; // [RULE10] [RULE11] [RULE12]
    assign adc_differential_reference  = (rf == acrmc_pkg::ACRMC_REF_EXT_DIFF); // [RULE12]

    // Start pin only counts while it owns the shared pin
    assign start_request = shared_pin_is_start ? start_rise : scan_request;

    // =========================================================
    // Delay clock: internal divider or host serial clock
    // =========================================================
    localparam int DIV_W = $clog2(INT_DIV);
    logic [DIV_W-1:0]           div_q;
    logic                       int_tick;
    logic                       delay_tick;

    assign int_tick   = (div_q == $clog2(INT_DIV)'(INT_DIV - 1));
    assign delay_tick = ext_clk ? (sclk_rise && cs_active) : int_tick; // [RULE5] [RULE7]

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            div_q <= '0;
        end else begin
            div_q <= int_tick ? '0 : div_q + DIV_W'(1);
        end
    end

    // =========================================================
    // Reference power and delay counters
    // =========================================================
    logic [8:0] wait_q;
    logic [8:0] temp_q;
    logic       busy_q;
    logic       need_ref;
    logic       temp_phase_q;

    // Temperature always needs the reference
    assign need_ref = scan_temperature || adc_uses_internal_reference; // [RULE6]

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            internal_reference_on <= 1'b0;
            wait_q                <= 9'h000;
            temp_q                <= 9'h000;
            busy_q                <= 1'b0;
            temp_phase_q          <= 1'b0;
            conversion_go         <= 1'b0;
            temperature_ready     <= 1'b0;
        end else begin
            conversion_go     <= 1'b0;
            temperature_ready <= 1'b0;
            if (start_request && !busy_q) begin
                busy_q       <= 1'b1;
                temp_phase_q <= scan_temperature;
                temp_q       <= scan_temperature ? 9'(`ACRMC_TEMP_CYCLES) : 9'h000;
                if (reference_override) begin
                    internal_reference_on <= 1'b1; // [RULE9]
                    wait_q <= scan_temperature ? 9'(`ACRMC_TEMP_CYCLES) : 9'h000; // [RULE9]
                    temp_q <= 9'h000;
                end else if (need_ref && !internal_reference_on) begin
                    internal_reference_on <= 1'b1;
                    // Counter reloads on every wake
                    wait_q <= scan_temperature ? 9'(`ACRMC_SETTLE_CYCLES)
                                               : 9'(`ACRMC_WAKE_CYCLES); // [RULE4] [RULE6] [RULE19]
                end else begin
                    wait_q <= 9'h000;
                end
                // Temperature tail only applies with the external clock
                if (!ext_clk) begin
                    temp_q <= 9'h000;
                end
            end else if (busy_q) begin
                if (wait_q != 9'h000) begin
                    if (delay_tick) begin
                        wait_q <= wait_q - 9'h001;
                    end
                end else if (temp_q != 9'h000) begin
                    if (delay_tick) begin
                        temp_q <= temp_q - 9'h001; // [RULE8]
                    end
                end else begin
                    busy_q            <= 1'b0;
                    conversion_go     <= 1'b1; // [RULE19]
                    temperature_ready <= temp_phase_q;
                end
            end
            // A scan taken in the same cycle keeps the reference up
            if (scan_done && !reference_override && !busy_q && !start_request) begin
                internal_reference_on <= 1'b0; // [RULE4] [RULE11]
            end
        end
    end
endmodule : acrmc_top

// [hdl/acrmc_defines.svh]
// Overview of operation
// [RULE1] Modes 00-10 internal clock; pin role by mode
// [RULE2] Mode 01: host times sampling via start pin
// [RULE3] Mode 11: serial clock is conversion clock
// [RULE4] Internal ref sleeps after scan; 218-cycle wake
// [RULE5] Mode 11 wake delay counts external clocks
// [RULE6] Temperature needs reference; 244-cycle settle delay
// [RULE7] Mode 11 settle delay counts external clocks
// [RULE8] Mode 11 temperature result after 188 more
// [RULE9] Override keeps reference on; 188-cycle delay
// [RULE10] Mode 01: external single-ended, shared pin reference
// [RULE11] Mode 10 default: internal ref, sleeps after scan
// [RULE12] Mode 11: external differential, internal unused
// [RULE13] Target 10 writes next byte to unipolar
// [RULE14] Target 11 writes next byte to bipolar
// [RULE15] Setup byte is 01 in bits 7:6
// [RULE16] Upper clock-mode bit resets to one
// [RULE17] Host holds select low sixteen clocks
// [RULE18] Targets 00/01 write no pair register
// [RULE19] First conversion waits for all delay counters
`ifndef ACRMC_DEFINES_SVH
`define ACRMC_DEFINES_SVH
`define ACRMC_SETUP_ID        2'h1
`define ACRMC_ID_HI           7
`define ACRMC_ID_LO           6
`define ACRMC_CLK_HI          5
`define ACRMC_CLK_LO          4
`define ACRMC_REF_HI          3
`define ACRMC_REF_LO          2
`define ACRMC_PAIR_HI         1
`define ACRMC_PAIR_LO         0
`define ACRMC_CLK_RESET       2'h2
`define ACRMC_REF_RESET       2'h2
`define ACRMC_PAIR_RESET      8'h00
`define ACRMC_WAKE_CYCLES     218
`define ACRMC_SETTLE_CYCLES   244
`define ACRMC_TEMP_CYCLES     188
`define ACRMC_INT_DIV         28
`endif

// [hdl/acrmc_pkg.sv]
package acrmc_pkg;
    typedef enum logic [1:0] {
        ACRMC_CLK_INT_START,
        ACRMC_CLK_INT_EXT_ACQ,
        ACRMC_CLK_INT_AIN,
        ACRMC_CLK_EXTERNAL
    } acrmc_clk_mode_t;
    typedef enum logic [1:0] {
        ACRMC_REF_INTERNAL,
        ACRMC_REF_EXT_SINGLE,
        ACRMC_REF_INT_ADC,
        ACRMC_REF_EXT_DIFF
    } acrmc_ref_mode_t;
endpackage : acrmc_pkg

// [hdl/acrmc_pin_sync.sv]
`timescale 1ns/1ps
// Three-stage sampler; a change counts when stages two and three agree
module acrmc_pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clock,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            level <= '0;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level[i] <= s3_q[i];
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_edge
            assign rise[g] = (s2_q[g] == s3_q[g]) && s3_q[g] && !level[g];
        end
    endgenerate
endmodule : acrmc_pin_sync

// [test/acrmc_checker.sv]
`timescale 1ns/1ps
// ====
// Port relations of the setup decoder
module acrmc_checker (
    input wire logic       clock,
    input wire logic       reset,
    input wire logic [1:0] clock_mode_select,
    input wire logic [1:0] reference_mode_select,
    input wire logic [1:0] pair_mode_target_select,
    input wire logic       host_timed_acquisition,
    input wire logic       serial_timed_acquisition,
    input wire logic       shared_pin_is_start,
    input wire logic       adc_uses_internal_reference,
    input wire logic       adc_differential_reference,
    input wire logic       internal_reference_on,
    input wire logic [7:0] unipolar_pairs,
    input wire logic [7:0] bipolar_pairs,
    input wire logic       conversion_go,
    input wire logic       temperature_ready,
    input wire logic       start_request,
    input wire logic       scan_request
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    a_pin_role: assert property (
        shared_pin_is_start == !clock_mode_select[1])
        else $error("shared pin role wrong");
    a_host_timed: assert property (
        host_timed_acquisition == (clock_mode_select == 2'h1))
        else $error("host timing decode wrong");
    a_serial_timed: assert property (
        serial_timed_acquisition == (clock_mode_select == 2'h3))
        else $error("serial timing decode wrong");
    a_ref_internal: assert property (
        adc_uses_internal_reference == !reference_mode_select[0])
        else $error("internal reference use wrong");
    a_ref_diff: assert property (
        adc_differential_reference == (reference_mode_select == 2'h3))
        else $error("differential reference wrong");
    a_unipolar_write: assert property (
        $changed(unipolar_pairs) |-> pair_mode_target_select == 2'h2)
        else $error("unipolar write without target");
    a_bipolar_write: assert property (
        $changed(bipolar_pairs) |-> pair_mode_target_select == 2'h3)
        else $error("bipolar write without target");
    a_reset_mode: assert property (
        $fell(reset) |-> clock_mode_select == 2'h2)
        else $error("clock mode not out of reset");
    a_temp_go: assert property (
        temperature_ready |-> conversion_go && internal_reference_on)
        else $error("temperature ready without go");
    a_start_source: assert property (
        !shared_pin_is_start |-> start_request == scan_request)
        else $error("start source wrong for analog pin");
endmodule : acrmc_checker

// [test/acrmc_spi_host.sv]
`timescale 1ns/1ps
// ====
// Host side of the serial link
module acrmc_spi_host (
    output logic serial_clock,
    output logic chip_select_n,
    output logic serial_data_in
);
    initial begin
        serial_clock = 1'b0;
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
    end
    task automatic frame(input logic [15:0] w, input logic two);
        chip_select_n = 1'b0;
        for (int i = 15; i >= (two ? 0 : 8); i--) begin
            serial_data_in = w[i];
            #40 serial_clock = 1'b1;
            #40 serial_clock = 1'b0;
        end
        #40 chip_select_n = 1'b1;
        // Released line shows no stale bit
        serial_data_in = ~serial_data_in;
    endtask : frame
    // Ones shift in as ignored command bytes; 280 ns keeps under the rate limit
    task automatic burst(input int n);
        chip_select_n = 1'b0;
        serial_data_in = 1'b1;
        repeat (n) begin
            #140 serial_clock = 1'b1;
            #140 serial_clock = 1'b0;
        end
        chip_select_n = 1'b1;
        serial_data_in = 1'b0;
    endtask : burst
endmodule : acrmc_spi_host

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench;
    localparam int DIV = 8;
    logic       clock = 1'b0;
    logic       reset = 1'b1;
    logic       conversion_start_pin_n = 1'b1;
    logic       scan_request = 1'b0;
    logic       scan_temperature = 1'b0;
    logic       scan_done = 1'b0;
    logic       reference_override = 1'b0;
    wire logic  serial_clock, chip_select_n, serial_data_in;
    logic [1:0] clock_mode_select, reference_mode_select, pair_mode_target_select;
    logic       use_internal_conv_clock, host_timed_acquisition, serial_timed_acquisition;
    logic       shared_pin_is_start, shared_pin_is_reference, adc_uses_internal_reference;
    logic       adc_differential_reference, internal_reference_on, start_request;
    logic       conversion_go, temperature_ready;
    logic [7:0] unipolar_pairs, bipolar_pairs, d, exp_up = 8'h00, exp_bp = 8'h00;
    int         failures = 0, cmp_count = 0, seed = 31, cyc = 0;
    acrmc_top #(.INT_DIV(DIV)) acrmc_top_inst (.*);
    acrmc_spi_host acrmc_spi_host_inst (.*);
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures++;
            results();
        end
    end
    function automatic logic [6:0] decode(input logic [1:0] c, r);
        return {c != 2'h3, c == 2'h1, c == 2'h3, !c[1], !r[0], r == 2'h3, r[0]};
    endfunction : decode
    task automatic check(input logic [23:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic check_range(input int got, lo, hi);
        cmp_count++;
        if (got < lo || got > hi) begin
            failures++;
            $display("unexpected at %0t got %h exp %h", $time, got, lo);
        end
    endtask : check_range
    task automatic fields(input logic [5:0] e);
        check({18'h0, clock_mode_select, reference_mode_select, pair_mode_target_select}, e);
        check({unipolar_pairs, bipolar_pairs}, {exp_up, exp_bp});
    endtask : fields
    task automatic setup(input logic [1:0] c, r, p, input logic [7:0] b);
        logic [6:0] got;
        acrmc_spi_host_inst.frame({2'h1, c, r, p, b}, p[1]);
        if (p == 2'h2) exp_up = b;
        if (p == 2'h3) exp_bp = b;
        repeat (8) @(negedge clock);
        fields({c, r, p});
        got = {use_internal_conv_clock, host_timed_acquisition, serial_timed_acquisition,
               shared_pin_is_start, adc_uses_internal_reference, adc_differential_reference,
               shared_pin_is_reference};
        check(got, decode(c, r));
    endtask : setup
    task automatic scan(input logic t, ov, pin, input int ticks, per);
        int n;
        n = 0;
        @(posedge clock);
        reference_override <= ov;
        scan_temperature <= t;
        if (pin) conversion_start_pin_n <= 1'b0;
        else scan_request <= 1'b1;
        // Held three cycles so a repeat while busy must be refused
        repeat (3) @(posedge clock);
        scan_request <= 1'b0;
        conversion_start_pin_n <= 1'b1;
        while (conversion_go !== 1'b1 && n < 20000) begin
            @(negedge clock);
            n++;
        end
        check({23'h0, temperature_ready}, {23'h0, t});
        check({23'h0, internal_reference_on}, 24'h1);
        // First link tick lands half a period in, so the floor is one period short
        check_range(n, ticks * per - per, ticks * per + per + 8);
        @(posedge clock);
        reference_override <= 1'b0;
        scan_done <= 1'b1;
        @(posedge clock);
        scan_done <= 1'b0;
        scan_temperature <= 1'b0;
        @(negedge clock);
        check({23'h0, internal_reference_on}, 24'h0);
    endtask : scan
    task automatic results;
        $display("failures %0d compares %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results
    // ====
    // Stimulus
    initial begin
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        repeat (6) @(negedge clock);
        check({clock_mode_select, reference_mode_select, pair_mode_target_select,
               unipolar_pairs, bipolar_pairs, internal_reference_on}, {4'ha, 19'h0});
        for (int i = 0; i < 16; i++) begin
            d = $random(seed);
            setup(i[3:2], i[1:0], d[1:0], d);
        end
        setup(2'h2, 2'h0, 2'h2, $random(seed));
        setup(2'h2, 2'h1, 2'h3, $random(seed));
        // Byte after a 01 target is a fresh setup command
        acrmc_spi_host_inst.frame({8'h69, 8'h5b}, 1'b1);
        repeat (8) @(negedge clock);
        fields(6'h1b);
        acrmc_spi_host_inst.frame({8'hea, 8'h00}, 1'b0);
        repeat (8) @(negedge clock);
        fields(6'h1b);
        setup(2'h2, 2'h2, 2'h0, 8'h00);
        scan(0, 0, 0, 218, DIV);
        scan(1, 0, 0, 244, DIV);
        scan(1, 1, 0, 188, DIV);
        setup(2'h1, 2'h2, 2'h0, 8'h00);
        scan(0, 0, 1, 218, DIV);
        setup(2'h3, 2'h2, 2'h0, 8'h00);
        fork
            acrmc_spi_host_inst.burst(224);
            scan(0, 0, 0, 218, 28);
        join
        fork
            acrmc_spi_host_inst.burst(438);
            scan(1, 0, 0, 432, 28);
        join
        results();
    end
endmodule : testbench
bind acrmc_top acrmc_checker acrmc_checker_inst (.*);
